// ==== logic/wcl_defines.vh ====
`ifndef WCL_DEFINES_VH
`define WCL_DEFINES_VH

// register byte offsets
`define WCL_OFF_CTRL       8'h00
`define WCL_OFF_PART       8'h04
`define WCL_OFF_POST       8'h08
`define WCL_OFF_STATUS     8'h0C
`define WCL_OFF_MASK       8'h10
`define WCL_OFF_STATE      8'h14
`define WCL_OFF_CAP_ADDR   8'h18
`define WCL_OFF_CAP_DATA   8'h1C
`define WCL_OFF_TRIP_IDX   8'h20
`define WCL_OFF_TRIP_DATA  8'h24
`define WCL_OFF_EVT_IDX    8'h28
`define WCL_OFF_EVT_DATA   8'h2C
`define WCL_OFF_COUNTS     8'h30
`define WCL_OFF_TIME_MS    8'h34
`define WCL_OFF_TRIG_SEL   8'h38

// ctrl fields
`define WCL_CTRL_ENABLE    0
`define WCL_CTRL_FREQ60    1
`define WCL_CTRL_COMTRADE  2
`define WCL_CTRL_SW_TRIG   3

// status / mask fields
`define WCL_ST_CAP_DONE    0
`define WCL_ST_TRIP        1
`define WCL_ST_EVENT       2
`define WCL_ST_WIDTH       3

// reset values
`define WCL_RST_CTRL       4'h1
`define WCL_RST_PART       5'h01
`define WCL_RST_POST       13'h0040
`define WCL_RST_TRIG_SEL   14'h0000

// sizes
`define WCL_CHANNELS       12
`define WCL_MAX_CYCLES     416
`define WCL_SPC            16
`define WCL_CAP_DEPTH      (`WCL_MAX_CYCLES * `WCL_SPC)
`define WCL_CAP_AW         13
`define WCL_MAX_PART       16
`define WCL_TRIP_DEPTH     32
`define WCL_TRIP_WORDS     8
`define WCL_EVT_DEPTH      512
`define WCL_EVT_WORDS      4

// timing: 200 MHz clock
`define WCL_CLK_HZ         200000000
`define WCL_MS_NS          1000000
`define WCL_MS_CYCLES      (`WCL_CLK_HZ / 1000)
`define WCL_SAMPLE_DIV_50  (`WCL_CLK_HZ / (50 * `WCL_SPC))
`define WCL_SAMPLE_DIV_60  (`WCL_CLK_HZ / (60 * `WCL_SPC))

`endif

// ==== logic/wcl_ram.v ====
`timescale 1ns/1ps
`default_nettype none

// single port write, registered read memory
module wcl_ram #(
    parameter DW    = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire          aclk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:DEPTH-1];

    always @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // wcl_ram

`default_nettype wire

// ==== logic/wcl_top.v ====
// Operation
// - capture memory holds 416 cycles, all channels
// - capture memory split into 1 to 16 partitions
// - sample at sixteen times 50/60 Hz
// - trigger from inputs, trips or command
// - untriggered, capture writes continuously
// - keep pre-trigger data, post delay, close
// - COMTRADE select bit held in ctrl, not acted on by capture
// - capture records are volatile
// - keep 32 most recent trip records
// - trip record: functions, I/O, time, currents
// - log events with 1 ms time stamp
// - event log keeps 512 most recent
// - event log entries are volatile
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wcl_defines.vh"

module wcl_top (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [191:0] sample_data,
    input  wire [13:0]  status_in,
    input  wire [22:0]  trip_out,
    input  wire [31:0]  func_operated,
    input  wire [31:0]  func_pickup,
    input  wire [63:0]  trip_currents,
    input  wire         event_strobe,
    input  wire [31:0]  element_status,
    input  wire [31:0]  measured_value,
    input  wire [31:0]  calculated_value,
    input  wire [31:0]  s_axi_awaddr,
    input  wire         s_axi_awvalid,
    output wire         s_axi_awready,
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    input  wire         s_axi_wvalid,
    output wire         s_axi_wready,
    output reg  [1:0]   s_axi_bresp,
    output reg          s_axi_bvalid,
    input  wire         s_axi_bready,
    input  wire [31:0]  s_axi_araddr,
    input  wire         s_axi_arvalid,
    output wire         s_axi_arready,
    output reg  [31:0]  s_axi_rdata,
    output reg  [1:0]   s_axi_rresp,
    output reg          s_axi_rvalid,
    input  wire         s_axi_rready,
    output wire         irq
);
    // ==========================================================
    // pin synchronisers
    reg  [13:0] in_meta;
    reg  [13:0] in_sync;
    reg  [13:0] in_prev;
    reg  [22:0] trip_meta;
    reg  [22:0] trip_sync;
    reg  [22:0] trip_prev;
    always @(posedge aclk) begin
        in_meta   <= status_in;
        in_sync   <= in_meta;
        in_prev   <= in_sync;
        trip_meta <= trip_out;
        trip_sync <= trip_meta;
        trip_prev <= trip_sync;
    end
    wire        trip_rise = |(trip_sync & ~trip_prev);
    wire [13:0] in_rise   = in_sync & ~in_prev;

    // ==========================================================
    // registers
    reg  [3:0]  ctrl;
    reg  [4:0]  part_count;
    reg  [12:0] post_len;
    reg  [13:0] trig_sel;
    reg  [2:0]  status;
    reg  [2:0]  mask;
    reg  [12:0] cap_raddr;
    reg  [4:0]  trip_idx;
    reg  [8:0]  evt_idx;
    reg  [2:0]  trip_word;
    reg  [1:0]  evt_word;
    reg         sw_trig;
    wire        en       = ctrl[`WCL_CTRL_ENABLE];
    wire        ar_hs    = s_axi_arvalid && s_axi_arready;

    // ==========================================================
    // time base: 1 ms tick and millisecond stamp
    reg  [17:0] ms_div;
    reg  [31:0] time_ms;
    wire        ms_tick = (ms_div == `WCL_MS_CYCLES - 1);
    always @(posedge aclk) begin
        if (!aresetn) begin
            ms_div  <= 18'h00000;
            time_ms <= 32'h00000000;
        end else begin
            ms_div  <= ms_tick ? 18'h00000 : ms_div + 18'h00001;
            time_ms <= ms_tick ? time_ms + 32'h00000001 : time_ms;
        end
    end

    // ==========================================================
    // sample clock: 16 samples per nominal cycle
    reg  [17:0] smp_div;
    wire [31:0] smp_full = ctrl[`WCL_CTRL_FREQ60] ? (`WCL_SAMPLE_DIV_60 - 1) :
                                                  (`WCL_SAMPLE_DIV_50 - 1);
    wire [17:0] smp_top  = smp_full[17:0];
    wire        smp_tick = (smp_div >= smp_top);
    always @(posedge aclk) begin
        if (!aresetn) begin
            smp_div <= 18'h00000;
        end else begin
            smp_div <= smp_tick ? 18'h00000 : smp_div + 18'h00001;
        end
    end

    // ==========================================================
    // capture state machine
    localparam CS_IDLE = 3'b001;
    localparam CS_PRE  = 3'b010;
    localparam CS_POST = 3'b100;
    reg  [2:0]  cap_state;
    reg  [12:0] part_len;
    reg  [12:0] part_base;
    reg  [12:0] part_ofs;
    reg  [12:0] post_cnt;
    reg  [3:0]  cur_part;
    reg  [12:0] trig_ofs;
    reg  [3:0]  last_part;
    wire [31:0] part_div = `WCL_CAP_DEPTH / part_count;
    wire        trig_hit = sw_trig | (|(in_rise & trig_sel)) | trip_rise;
    wire        cap_we   = smp_tick && en && (cap_state != CS_IDLE);
    wire [12:0] cap_wa   = part_base + part_ofs;
    wire        evt_cap_done = (cap_state == CS_POST) && smp_tick &&
                               (post_cnt == 13'h0000);

    always @(posedge aclk) begin
        if (!aresetn) begin
            cap_state <= CS_IDLE;
            part_len  <= 13'h0000;
            part_base <= 13'h0000;
            part_ofs  <= 13'h0000;
            post_cnt  <= 13'h0000;
            cur_part  <= 4'h0;
            trig_ofs  <= 13'h0000;
            last_part <= 4'h0;
        end else begin
            case (cap_state)
                CS_IDLE: begin
                    if (en) begin
                        part_len  <= part_div[12:0];
                        part_base <= 13'h0000;
                        part_ofs  <= 13'h0000;
                        cur_part  <= 4'h0;
                        cap_state <= CS_PRE;
                    end
                end
                CS_PRE: begin
                    if (!en) begin
                        cap_state <= CS_IDLE;
                    end else begin
                        if (smp_tick) begin
                            part_ofs <= (part_ofs == part_len - 13'h0001) ?
                                        13'h0000 : part_ofs + 13'h0001;
                        end
                        if (trig_hit) begin
                            trig_ofs  <= part_ofs;
                            post_cnt  <= post_len;
                            cap_state <= CS_POST;
                        end
                    end
                end
                CS_POST: begin
                    if (smp_tick) begin
                        part_ofs <= (part_ofs == part_len - 13'h0001) ?
                                    13'h0000 : part_ofs + 13'h0001;
                        if (post_cnt == 13'h0000) begin
                            last_part <= cur_part;
                            part_ofs  <= 13'h0000;
                            if (cur_part == part_count[3:0] - 4'h1) begin
                                cur_part  <= 4'h0;
                                part_base <= 13'h0000;
                            end else begin
                                cur_part  <= cur_part + 4'h1;
                                part_base <= part_base + part_len;
                            end
                            cap_state <= CS_PRE;
                        end else begin
                            post_cnt <= post_cnt - 13'h0001;
                        end
                    end
                end
                default: cap_state <= CS_IDLE;
            endcase
        end
    end

    wire [191:0] cap_rdata;
    // volatile: contents are undefined after power-up
    wcl_ram #(.DW(192), .DEPTH(`WCL_CAP_DEPTH), .AW(`WCL_CAP_AW)) u_cap_ram (
        .aclk  (aclk),
        .we    (cap_we),
        .waddr (cap_wa),
        .wdata (sample_data),
        .raddr (cap_raddr),
        .rdata (cap_rdata)
    );

    // ==========================================================
    // trip records: ring of 32, overwrite oldest
    reg  [4:0]  trip_wp;
    reg  [5:0]  trip_cnt;
    reg  [2:0]  trip_wcnt;
    reg         trip_busy;
    reg  [255:0] trip_rec;
    wire        evt_trip = trip_rise && en && !trip_busy;
    always @(posedge aclk) begin
        if (!aresetn) begin
            trip_wp   <= 5'h00;
            trip_cnt  <= 6'h00;
            trip_busy <= 1'b0;
            trip_wcnt <= 3'h0;
            trip_rec  <= 256'h0;
        end else if (evt_trip) begin
            trip_rec  <= {32'h0, trip_currents, 27'h0, in_sync, trip_sync, time_ms,
                          func_pickup, func_operated};
            trip_busy <= 1'b1;
            trip_wcnt <= 3'h0;
        end else if (trip_busy) begin
            trip_wcnt <= trip_wcnt + 3'h1;
            if (trip_wcnt == 3'h7) begin
                trip_busy <= 1'b0;
                trip_wp   <= trip_wp + 5'h01;
                trip_cnt  <= (trip_cnt == 6'h20) ? trip_cnt : trip_cnt + 6'h01;
            end
        end
    end
    wire [31:0] trip_wdata = trip_rec[trip_wcnt*32 +: 32];
    wire [31:0] trip_rdata;
    wcl_ram #(.DW(32), .DEPTH(`WCL_TRIP_DEPTH * `WCL_TRIP_WORDS), .AW(8)) u_trip_ram (
        .aclk  (aclk),
        .we    (trip_busy),
        .waddr ({trip_wp, trip_wcnt}),
        .wdata (trip_wdata),
        .raddr ({trip_idx, ar_hs ? s_axi_araddr[10:8] : trip_word}),
        .rdata (trip_rdata)
    );

    // ==========================================================
    // sequence of events log: ring of 512, overwrite oldest
    reg  [8:0]   evt_wp;
    reg  [9:0]   evt_cnt;
    reg  [1:0]   evt_wcnt;
    reg          evt_busy;
    reg  [127:0] evt_rec;
    wire         evt_log = event_strobe && en && !evt_busy;
    always @(posedge aclk) begin
        if (!aresetn) begin
            evt_wp   <= 9'h000;
            evt_cnt  <= 10'h000;
            evt_busy <= 1'b0;
            evt_wcnt <= 2'h0;
            evt_rec  <= 128'h0;
        end else if (evt_log) begin
            evt_rec  <= {calculated_value, measured_value,
                         element_status[31:14], in_sync, time_ms};
            evt_busy <= 1'b1;
            evt_wcnt <= 2'h0;
        end else if (evt_busy) begin
            evt_wcnt <= evt_wcnt + 2'h1;
            if (evt_wcnt == 2'h3) begin
                evt_busy <= 1'b0;
                evt_wp   <= evt_wp + 9'h001;
                evt_cnt  <= (evt_cnt == 10'h200) ? evt_cnt : evt_cnt + 10'h001;
            end
        end
    end
    wire [31:0] evt_wdata = evt_rec[evt_wcnt*32 +: 32];
    wire [31:0] evt_rdata;
    // volatile: contents are undefined after power-up
    wcl_ram #(.DW(32), .DEPTH(`WCL_EVT_DEPTH * `WCL_EVT_WORDS), .AW(11)) u_evt_ram (
        .aclk  (aclk),
        .we    (evt_busy),
        .waddr ({evt_wp, evt_wcnt}),
        .wdata (evt_wdata),
        .raddr ({evt_idx, ar_hs ? s_axi_araddr[9:8] : evt_word}),
        .rdata (evt_rdata)
    );

    // ==========================================================
    // axi4-lite slave
    reg  [31:0] aw_addr;
    reg         aw_full;
    reg  [31:0] w_data;
    reg         w_full;
    reg         rd_pend;
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid && !rd_pend;
    wire        do_wr  = aw_full && w_full;
    wire [7:0]  wa     = aw_addr[7:0];
    wire [2:0]  ev_set = {evt_log, evt_trip, evt_cap_done};
    wire [2:0]  w1c    = (do_wr && wa == `WCL_OFF_STATUS) ? w_data[2:0] : 3'h0;
    assign irq = |(status & mask);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0; w_full <= 1'b0;
            aw_addr <= 32'h0; w_data <= 32'h0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
            ctrl <= `WCL_RST_CTRL; part_count <= `WCL_RST_PART;
            post_len <= `WCL_RST_POST; trig_sel <= `WCL_RST_TRIG_SEL;
            mask <= 3'h0; status <= 3'h0; sw_trig <= 1'b0;
            cap_raddr <= 13'h0000; trip_idx <= 5'h00; evt_idx <= 9'h000;
        end else begin
            sw_trig <= 1'b0;
            status  <= (status & ~w1c) | ev_set; // set wins over clear
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr; aw_full <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata; w_full <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
            if (do_wr) begin
                aw_full <= 1'b0; w_full <= 1'b0;
                s_axi_bvalid <= 1'b1; s_axi_bresp <= 2'h0;
                case (wa)
                    `WCL_OFF_CTRL: begin
                        ctrl    <= {1'b0, w_data[2:0]};
                        sw_trig <= w_data[`WCL_CTRL_SW_TRIG];
                    end
                    `WCL_OFF_PART:
                        if (w_data[4:0] != 5'h00 && w_data[4:0] <= 5'h10 && !en)
                            part_count <= w_data[4:0];
                    `WCL_OFF_POST:     post_len  <= w_data[12:0];
                    `WCL_OFF_STATUS:   ;
                    `WCL_OFF_MASK:     mask      <= w_data[2:0];
                    `WCL_OFF_CAP_ADDR: cap_raddr <= w_data[12:0];
                    `WCL_OFF_TRIP_IDX: trip_idx  <= w_data[4:0];
                    `WCL_OFF_EVT_IDX:  evt_idx   <= w_data[8:0];
                    `WCL_OFF_TRIG_SEL: trig_sel  <= w_data[13:0];
                    default:           s_axi_bresp <= 2'h2;
                endcase
            end
        end
    end

    // read path: two cycles so memory data are registered first
    reg  [7:0]  ra;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend <= 1'b0; ra <= 8'h00;
            trip_word <= 3'h0; evt_word <= 2'h0;
            s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h0;
        end else begin
            if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
            if (ar_hs) begin
                ra        <= s_axi_araddr[7:0];
                trip_word <= s_axi_araddr[10:8];
                evt_word  <= s_axi_araddr[9:8];
                rd_pend   <= 1'b1;
            end
            if (rd_pend) begin
                rd_pend      <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (ra)
                    `WCL_OFF_CTRL:      s_axi_rdata <= {28'h0, ctrl};
                    `WCL_OFF_PART:      s_axi_rdata <= {27'h0, part_count};
                    `WCL_OFF_POST:      s_axi_rdata <= {19'h0, post_len};
                    `WCL_OFF_STATUS:    s_axi_rdata <= {29'h0, status};
                    `WCL_OFF_MASK:      s_axi_rdata <= {29'h0, mask};
                    `WCL_OFF_STATE:     s_axi_rdata <= {4'h0, last_part, trig_ofs,
                                                        cur_part, 4'h0, cap_state};
                    `WCL_OFF_CAP_ADDR:  s_axi_rdata <= {19'h0, cap_raddr};
                    `WCL_OFF_CAP_DATA:  s_axi_rdata <= cap_rdata[31:0];
                    `WCL_OFF_TRIP_IDX:  s_axi_rdata <= {27'h0, trip_idx};
                    `WCL_OFF_TRIP_DATA: s_axi_rdata <= trip_rdata;
                    `WCL_OFF_EVT_IDX:   s_axi_rdata <= {23'h0, evt_idx};
                    `WCL_OFF_EVT_DATA:  s_axi_rdata <= evt_rdata;
                    `WCL_OFF_COUNTS:    s_axi_rdata <= {6'h0, evt_cnt, 10'h0, trip_cnt};
                    `WCL_OFF_TIME_MS:   s_axi_rdata <= time_ms;
                    `WCL_OFF_TRIG_SEL:  s_axi_rdata <= {18'h0, trig_sel};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
        end
    end
endmodule // wcl_top

`default_nettype wire

// ==== bench/wcl_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// axi slave port checker
module wcl_top_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    default clocking cb @(posedge aclk);
    endclocking

    AST_RST_QUIET: assert property (!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active after reset");
    AST_B_HOLD: assert property (disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (disable iff (!aresetn) s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    AST_W_BLOCK: assert property (disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    AST_R_BLOCK: assert property (disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    AST_R_LAT: assert property (disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read latency wrong");
    AST_B_LAT: assert property (disable iff (!aresetn) s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write latency wrong");
    AST_ERR_ZERO: assert property (disable iff (!aresetn) s_axi_rvalid && s_axi_rresp != 2'h0
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("bad read error response");
    AST_B_END: assert property (disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_END: assert property (disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule // wcl_top_chk

bind wcl_top wcl_top_chk wcl_top_chk_i (.*);
`default_nettype wire

// ==== bench/wcl_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// front end and trip logic stand-in
module wcl_front_model (
    input  wire logic         aclk,
    output var  logic [191:0] sample_data,
    output var  logic [13:0]  status_in,
    output var  logic [22:0]  trip_out,
    output var  logic         event_strobe
);
    logic [15:0] ramp = 16'h0;

    initial begin
        sample_data = 192'h0;
        status_in = 14'h0;
        trip_out = 23'h0;
        event_strobe = 1'b0;
    end

    // each channel rides the ramp with its own offset
    always @(posedge aclk) begin
        ramp <= ramp + 16'h1;
        for (int c = 0; c < 12; c++)
            sample_data[c*16 +: 16] <= ramp + 16'(c);
    end

    // kind 0 control input, 1 trip output, 2 event strobe
    task automatic pulse(input int kind, input int b);
        @(posedge aclk);
        if (kind == 0) status_in[b] <= 1'b1;
        else if (kind == 1) trip_out[b] <= 1'b1;
        else event_strobe <= 1'b1;
        repeat (kind == 2 ? 1 : 4) @(posedge aclk);
        status_in <= 14'h0;
        trip_out <= 23'h0;
        event_strobe <= 1'b0;
        repeat (kind == 2 ? 5 : 4) @(posedge aclk);
    endtask
endmodule // wcl_front_model
`default_nettype wire

// ==== bench/wcl_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module wcl_top_tb_top;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    wire  [191:0] sample_data;
    wire  [13:0]  status_in;
    wire  [22:0]  trip_out;
    wire          event_strobe;
    logic [31:0]  func_operated = 32'h0, func_pickup = 32'h0;
    logic [63:0]  trip_currents = 64'h0;
    logic [31:0]  element_status = 32'h0, measured_value = 32'h0, calculated_value = 32'h0;
    logic [31:0]  s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]   s_axi_wstrb = 4'hF;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire  [1:0]   s_axi_bresp, s_axi_rresp;
    wire  [31:0]  s_axi_rdata;
    int           num_errors = 0, tests_run = 0;
    logic [31:0]  rd;
    logic [1:0]   rs;

    always #2.5 aclk = ~aclk;

    wcl_top wcl_top_i (.*);
    wcl_front_model fe (.*);

    // ==========
    // reporting
    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            num_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // ==========
    // bus tasks
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit aw, w, done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= {20'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!done) chk(1'b0, "write stalled");
        if (!done) summarize();
    endtask

    task automatic rdr(input logic [11:0] a);
        bit ar, done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= {20'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!done) chk(1'b0, "read stalled");
        if (!done) summarize();
    endtask

    task automatic rexp(input logic [11:0] a, input logic [31:0] e, input string m);
        rdr(a);
        chk(rd === e && rs === 2'h0, m);
    endtask

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // ==========
    // scenarios
    task automatic t_regs;
        rexp(12'h000, 32'h1, "ctrl reset");
        rexp(12'h004, 32'h1, "part reset");
        rexp(12'h008, 32'h40, "post reset");
        rexp(12'h038, 32'h0, "trig reset");
        rexp(12'h00C, 32'h0, "status reset");
        rexp(12'h030, 32'h0, "counts reset");
        rdr(12'h03C);
        chk(rs === 2'h2 && rd === 32'h0, "unmapped read");
        wr(12'h03C, 32'hFFFF_FFFF);
        chk(rs === 2'h2, "unmapped write");
    endtask

    task automatic t_part;
        wr(12'h004, 32'h10);
        rexp(12'h004, 32'h1, "part locked");
        wr(12'h000, 32'h6);
        rexp(12'h000, 32'h6, "ctrl bits");
        wr(12'h004, 32'h10);
        rexp(12'h004, 32'h10, "part 16");
        wr(12'h004, 32'h0);
        rexp(12'h004, 32'h10, "part 0 taken");
        wr(12'h004, 32'h11);
        rexp(12'h004, 32'h10, "part 17 taken");
        wr(12'h004, 32'h1);
        rexp(12'h004, 32'h1, "part 1");
        wr(12'h008, 32'h123);
        rexp(12'h008, 32'h123, "post delay");
        wr(12'h000, 32'h1);
    endtask

    // source 0 command, 1 control input, 2 trip output
    task automatic t_trig(input int src);
        logic [2:0] s0;
        do_reset();
        wr(12'h038, 32'h8);
        rdr(12'h014);
        s0 = rd[2:0];
        repeat (20) @(posedge aclk);
        rdr(12'h014);
        chk(rd[2:0] === s0, "state moved");
        if (src == 0) wr(12'h000, 32'h9);
        else fe.pulse(src == 1 ? 0 : 1, src == 1 ? 3 : 5);
        repeat (10) @(posedge aclk);
        rdr(12'h014);
        chk(rd[2:0] !== s0, "trigger not seen");
        rdr(12'h030);
        chk(rd[5:0] === (src == 2 ? 6'h1 : 6'h0), "trip count");
    endtask

    task automatic t_trip;
        logic [31:0] lo;
        do_reset();
        func_operated <= 32'hA5A5_0001;
        func_pickup <= 32'h5A5A_0002;
        trip_currents <= 64'h0123_4567_89AB_CDEF;
        fe.pulse(1, 0);
        wr(12'h020, 32'h0);
        rexp(12'h024, 32'hA5A5_0001, "operated");
        rexp(12'h124, 32'h5A5A_0002, "pickup");
        rdr(12'h524);
        lo = rd;
        rdr(12'h624);
        chk({rd, lo} === trip_currents || {lo, rd} === trip_currents, "currents");
        for (int i = 0; i < 32; i++) fe.pulse(1, i % 23);
        rdr(12'h030);
        chk(rd[5:0] === 6'h20, "trip store count");
    endtask

    task automatic t_event;
        int hits;
        do_reset();
        element_status <= 32'hE1E1_0000;
        measured_value <= 32'h3E3E_0004;
        wr(12'h010, 32'h4);
        fe.pulse(2, 0);
        chk(irq === 1'b1, "irq not raised");
        wr(12'h00C, 32'h4);
        chk(irq === 1'b0, "irq not cleared");
        wr(12'h010, 32'h0);
        fe.pulse(2, 0);
        chk(irq === 1'b0, "masked irq raised");
        wr(12'h010, 32'h4);
        chk(irq === 1'b1, "pending irq");
        wr(12'h00C, 32'h4);
        rdr(12'h030);
        chk(rd[25:16] === 10'h2, "event count");
        wr(12'h028, 32'h0);
        hits = 0;
        for (int w = 0; w < 4; w++) begin
            rdr({2'h0, w[1:0], 8'h2C});
            if (rd === element_status || rd === measured_value) hits++;
        end
        chk(hits == 2, "event contents");
        for (int i = 0; i < 511; i++) fe.pulse(2, 0);
        rdr(12'h030);
        chk(rd[25:16] === 10'h200, "event log count");
    endtask

    initial begin
        do_reset();
        t_regs();
        t_part();
        for (int s = 0; s < 3; s++) t_trig(s);
        t_trip();
        t_event();
        summarize();
    end
endmodule // wcl_top_tb_top
`default_nettype wire
